// *** hw/t16cc_pkg.sv ***
// Purpose: Shared constants and types of the 16-bit timer with capture.
// Assumes: An 8-bit register port with a 4-bit byte address.
// Notes: Offsets, fields, reset values and sequence limits live here.
package t16cc_pkg;

    // Register byte addresses.
    localparam logic [3:0] ADDR_CTRL_A = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B = 4'h1;
    localparam logic [3:0] ADDR_COUNT_LO = 4'h2;
    localparam logic [3:0] ADDR_COUNT_HI = 4'h3;
    localparam logic [3:0] ADDR_CAPTURE_LO = 4'h4;
    localparam logic [3:0] ADDR_CAPTURE_HI = 4'h5;
    localparam logic [3:0] ADDR_CMPA_LO = 4'h6;
    localparam logic [3:0] ADDR_CMPA_HI = 4'h7;
    localparam logic [3:0] ADDR_CMPB_LO = 4'h8;
    localparam logic [3:0] ADDR_CMPB_HI = 4'h9;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'ha;
    localparam logic [3:0] ADDR_FLAGS = 4'hb;
    localparam logic [3:0] ADDR_STATUS = 4'hc;

    // Field positions.
    localparam int CTRLA_WGM_LSB = 0;
    localparam int CTRLB_TICK_LSB = 0;
    localparam int CTRLB_WGM_LSB = 3;
    localparam int CTRLB_CMPSEL_BIT = 5;
    localparam int CTRLB_EDGE_BIT = 6;
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_CAP_BIT = 5;
    localparam int STATUS_CEIL_BIT = 0;
    localparam int STATUS_FLOOR_BIT = 1;

    // Writable bits of the control and mask registers.
    localparam logic [7:0] CTRLA_MASK = 8'h03;
    localparam logic [7:0] CTRLB_MASK = 8'h7f;
    localparam logic [7:0] IRQ_MASK_BITS = 8'h21;

    // Reset values.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // Count limits.
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_FLOOR = 16'h0000;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;

    // Tick source codes.
    localparam logic [2:0] TICK_STOP = 3'h0;
    localparam logic [2:0] TICK_SYS = 3'h1;
    localparam logic [2:0] TICK_PRE_BASE = 3'h2;
    localparam logic [2:0] TICK_EXT_FALL = 3'h6;
    localparam logic [2:0] TICK_EXT_RISE = 3'h7;

    typedef enum logic {
        T16CC_UP,
        T16CC_DOWN
    } t16cc_dir_t;

    typedef struct packed {
        logic enable;
        logic useComparator;
        logic risingEdge;
    } t16cc_cap_cfg_t;

endpackage

// *** hw/t16cc_capture_edge.sv ***
// Purpose: Edge detector that triggers a capture.
// Assumes: Both sources are synchronous to clk.
// Notes: The trigger is a one-cycle pulse from a flip-flop.
`timescale 1ns/100ps
module t16cc_capture_edge
    import t16cc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Configuration
    input wire t16cc_cap_cfg_t cfg,
    // Event sources
    input wire logic capturePin,
    input wire logic comparatorOut,
    // Result
    output logic trigger
);

    logic prev_reg;
    logic trigger_reg;
    wire logic level;
    wire logic risen;
    wire logic fallen;
    wire logic trigger_next;

    // Changing the source can itself look like an edge, as software expects.
    assign level = cfg.useComparator ? comparatorOut : capturePin;
    assign risen = level & ~prev_reg;
    assign fallen = ~level & prev_reg;
    assign trigger_next = cfg.enable & (cfg.risingEdge ? risen : fallen);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            prev_reg <= 1'h0;
            trigger_reg <= 1'h0;
        end else begin
            prev_reg <= level;
            trigger_reg <= trigger_next;
        end
    end

    assign trigger = trigger_reg;

endmodule

// *** hw/t16cc_timer.sv ***
// Purpose: 16-bit up/down timer counter with input capture.
// Assumes: An 8-bit register port; ticks and pins synchronous to clk.
// Notes: Prescaler, waveform outputs and noise filtering are outside.
// Contract
// - Counter high byte reached only through temp.
// - Count low read loads temp with high.
// - Count low write loads high from temp.
// - Temp keeps value across low-byte writes.
// - Tick increments, decrements or clears the counter.
// - Ceiling at top, floor at zero.
// - Tick source zero stops the counter.
// - Counter accessible whether or not ticks run.
// - Software write beats any count operation.
// - Count sequence follows four-bit waveform mode.
// - Overflow flag set per mode, may interrupt.
// - Capture on selected edge of pin/comparator.
// - Capture copies full 16-bit count.
// - Capture flag set with the copy.
// - Enabled capture flag interrupts, service clears it.
// - Writing one clears capture flag.
// - Capture writable only in capture-top modes.
// - One temp register serves all wide registers.
// - Compare reads bypass the temp register.
// - Counter maximum all ones, floor zero.
`timescale 1ns/100ps
module t16cc_timer
    import t16cc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    // Tick sources
    input wire logic [3:0] prescaleTick,
    input wire logic externalTickPin,
    // Capture sources
    input wire logic captureInputPin,
    input wire logic comparatorOutput,
    // Interrupt handshake
    output logic overflowIrq,
    output logic captureIrq,
    input wire logic overflowAck,
    input wire logic captureAck,
    // Count indications
    output logic atCeiling,
    output logic atFloor
);

    function automatic logic hit(input logic strobe, input logic [3:0] a,
                                 input logic [3:0] target);
        return strobe && (a == target);
    endfunction

    function automatic logic [15:0] modeTop(input logic [3:0] mode,
                                            input logic [15:0] cmpA,
                                            input logic [15:0] cap);
        logic [15:0] top;
        top = COUNT_MAX;
        unique case (mode)
            4'h1, 4'h5: top = TOP_8BIT;
            4'h2, 4'h6: top = TOP_9BIT;
            4'h3, 4'h7: top = TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf: top = cmpA;
            4'h8, 4'ha, 4'hc, 4'he: top = cap;
            4'h0, 4'hd: top = COUNT_MAX;
        endcase
        return top;
    endfunction

    function automatic logic modeDual(input logic [3:0] mode);
        return (mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
    endfunction

    function automatic logic modeOvfAtMax(input logic [3:0] mode);
        return (mode inside {4'h0, 4'h4, 4'hc, 4'hd});
    endfunction

    function automatic logic modeCapTop(input logic [3:0] mode);
        return (mode inside {4'h8, 4'ha, 4'hc, 4'he});
    endfunction

    // Reset release through two flip-flops.
    logic [1:0] rstPipe_reg;
    wire logic rstN;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstPipe_reg <= 2'h0;
        end else begin
            rstPipe_reg <= {rstPipe_reg[0], 1'h1};
        end
    end

    assign rstN = rstPipe_reg[1];

    // State.
    logic [7:0] ctrlA_reg;
    logic [7:0] ctrlB_reg;
    logic [7:0] mask_reg;
    logic [7:0] temp_reg;
    logic [15:0] count_reg;
    logic [15:0] capture_reg;
    logic [15:0] cmpA_reg;
    logic [15:0] cmpB_reg;
    logic ovfFlag_reg;
    logic capFlag_reg;
    logic extPrev_reg;
    t16cc_dir_t dir_reg;
    logic [7:0] readData_reg;
    logic overflowIrq_reg;
    logic captureIrq_reg;
    logic atCeiling_reg;
    logic atFloor_reg;

    // Register decode.
    wire logic wrCtrlA = hit(regWrite, regAddr, ADDR_CTRL_A);
    wire logic wrCtrlB = hit(regWrite, regAddr, ADDR_CTRL_B);
    wire logic wrMask = hit(regWrite, regAddr, ADDR_IRQ_MASK);
    wire logic wrFlags = hit(regWrite, regAddr, ADDR_FLAGS);
    wire logic wrCountLo = hit(regWrite, regAddr, ADDR_COUNT_LO);
    wire logic wrCaptureLo = hit(regWrite, regAddr, ADDR_CAPTURE_LO);
    wire logic wrCmpALo = hit(regWrite, regAddr, ADDR_CMPA_LO);
    wire logic wrCmpBLo = hit(regWrite, regAddr, ADDR_CMPB_LO);
    wire logic wrAnyHi = hit(regWrite, regAddr, ADDR_COUNT_HI)
                       | hit(regWrite, regAddr, ADDR_CAPTURE_HI)
                       | hit(regWrite, regAddr, ADDR_CMPA_HI)
                       | hit(regWrite, regAddr, ADDR_CMPB_HI);
    wire logic rdCountLo = hit(regRead, regAddr, ADDR_COUNT_LO);
    wire logic rdCaptureLo = hit(regRead, regAddr, ADDR_CAPTURE_LO);

    // Mode and sequence.
    wire logic [2:0] tickSel = ctrlB_reg[CTRLB_TICK_LSB +: 3];
    wire logic [3:0] mode = {ctrlB_reg[CTRLB_WGM_LSB +: 2],
                             ctrlA_reg[CTRLA_WGM_LSB +: 2]};
    wire logic [15:0] top = modeTop(mode, cmpA_reg, capture_reg);
    wire logic dual = modeDual(mode);
    wire logic capTop = modeCapTop(mode);
    wire logic atTopNow = (count_reg == top);
    wire logic atFloorNow = (count_reg == COUNT_FLOOR);

    // Tick selection.
    wire logic extRise = externalTickPin & ~extPrev_reg;
    wire logic extFall = ~externalTickPin & extPrev_reg;
    wire logic [2:0] preIdx = tickSel - TICK_PRE_BASE;
    wire logic timerTick = (tickSel == TICK_STOP) ? 1'h0 :
                           (tickSel == TICK_SYS) ? 1'h1 :
                           (tickSel == TICK_EXT_FALL) ? extFall :
                           (tickSel == TICK_EXT_RISE) ? extRise :
                           prescaleTick[preIdx[1:0]];

    // Counter step.
    wire logic goDown = dual && ((dir_reg == T16CC_DOWN) ? !atFloorNow
                                                          : atTopNow);
    wire logic clearNow = !dual && atTopNow;
    wire logic [15:0] stepped = clearNow ? COUNT_FLOOR :
                                goDown ? count_reg - 16'h0001 :
                                count_reg + 16'h0001;
    wire t16cc_dir_t dirStep = !dual ? T16CC_UP :
                               atTopNow ? T16CC_DOWN :
                               atFloorNow ? T16CC_UP : dir_reg;
    wire logic [15:0] writeWord = {temp_reg, regWriteData};
    // A software write replaces the tick's count step; direction and overflow still follow the tick.
    wire logic [15:0] count_next = wrCountLo ? writeWord :
                                   timerTick ? stepped : count_reg;
    wire t16cc_dir_t dir_next = timerTick ? dirStep : dir_reg;
    wire logic ovfEvent = timerTick && (dual ? atFloorNow :
                          modeOvfAtMax(mode) ? (count_reg == COUNT_MAX)
                                             : atTopNow);

    // Temporary high byte, shared by every wide register.
    wire logic [7:0] temp_next = wrAnyHi ? regWriteData :
                                 rdCountLo ? count_reg[15:8] :
                                 rdCaptureLo ? capture_reg[15:8] :
                                 temp_reg;

    // Capture.
    wire logic capTrigger;
    wire t16cc_cap_cfg_t capCfg = '{enable: !capTop,
        useComparator: ctrlB_reg[CTRLB_CMPSEL_BIT],
        risingEdge: ctrlB_reg[CTRLB_EDGE_BIT]};

    t16cc_capture_edge captureEdge (
        .clk(clk),
        .rstN(rstN),
        .cfg(capCfg),
        .capturePin(captureInputPin),
        .comparatorOut(comparatorOutput),
        .trigger(capTrigger)
    );

    wire logic [15:0] capture_next = capTrigger ? count_reg :
                                     (wrCaptureLo && capTop) ? writeWord :
                                     capture_reg;

    // Flags: a new event wins over a clear in the same cycle.
    wire logic ovfClear = (wrFlags && regWriteData[FLAG_OVF_BIT])
                        || overflowAck;
    wire logic capClear = (wrFlags && regWriteData[FLAG_CAP_BIT])
                        || captureAck;
    wire logic ovfFlag_next = ovfEvent || (ovfFlag_reg && !ovfClear);
    wire logic capFlag_next = capTrigger || (capFlag_reg && !capClear);

    // Read selection.
    wire logic [7:0] flagsByte = {2'h0, capFlag_reg, 4'h0, ovfFlag_reg};
    wire logic [7:0] statusByte = {6'h00, atFloor_reg, atCeiling_reg};
    wire logic [7:0] readMux =
        (regAddr == ADDR_CTRL_A) ? ctrlA_reg :
        (regAddr == ADDR_CTRL_B) ? ctrlB_reg :
        (regAddr == ADDR_COUNT_LO) ? count_reg[7:0] :
        (regAddr == ADDR_COUNT_HI) ? temp_reg :
        (regAddr == ADDR_CAPTURE_LO) ? capture_reg[7:0] :
        (regAddr == ADDR_CAPTURE_HI) ? temp_reg :
        (regAddr == ADDR_CMPA_LO) ? cmpA_reg[7:0] :
        (regAddr == ADDR_CMPA_HI) ? cmpA_reg[15:8] :
        (regAddr == ADDR_CMPB_LO) ? cmpB_reg[7:0] :
        (regAddr == ADDR_CMPB_HI) ? cmpB_reg[15:8] :
        (regAddr == ADDR_IRQ_MASK) ? mask_reg :
        (regAddr == ADDR_FLAGS) ? flagsByte :
        (regAddr == ADDR_STATUS) ? statusByte : RESET_BYTE;

    // Control registers.
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ctrlA_reg <= RESET_BYTE;
            ctrlB_reg <= RESET_BYTE;
            mask_reg <= RESET_BYTE;
        end else begin
            if (wrCtrlA) begin
                ctrlA_reg <= regWriteData & CTRLA_MASK;
            end
            if (wrCtrlB) begin
                ctrlB_reg <= regWriteData & CTRLB_MASK;
            end
            if (wrMask) begin
                mask_reg <= regWriteData & IRQ_MASK_BITS;
            end
        end
    end

    // Compare values; no double buffering is modelled.
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cmpA_reg <= RESET_WORD;
            cmpB_reg <= RESET_WORD;
        end else begin
            if (wrCmpALo) begin
                cmpA_reg <= writeWord;
            end
            if (wrCmpBLo) begin
                cmpB_reg <= writeWord;
            end
        end
    end

    // Counter, capture and temporary byte.
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            count_reg <= RESET_WORD;
            capture_reg <= RESET_WORD;
            temp_reg <= RESET_BYTE;
            dir_reg <= T16CC_UP;
            extPrev_reg <= 1'h0;
        end else begin
            count_reg <= count_next;
            capture_reg <= capture_next;
            temp_reg <= temp_next;
            dir_reg <= dir_next;
            extPrev_reg <= externalTickPin;
        end
    end

    // Flags, interrupt requests and indications.
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ovfFlag_reg <= 1'h0;
            capFlag_reg <= 1'h0;
            overflowIrq_reg <= 1'h0;
            captureIrq_reg <= 1'h0;
            atCeiling_reg <= 1'h0;
            atFloor_reg <= 1'h0;
        end else begin
            ovfFlag_reg <= ovfFlag_next;
            capFlag_reg <= capFlag_next;
            overflowIrq_reg <= ovfFlag_next & mask_reg[FLAG_OVF_BIT];
            captureIrq_reg <= capFlag_next & mask_reg[FLAG_CAP_BIT];
            atCeiling_reg <= (count_next == top);
            atFloor_reg <= (count_next == COUNT_FLOOR);
        end
    end

    // Read data stand for exactly one cycle after the strobe.
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            readData_reg <= RESET_BYTE;
        end else begin
            readData_reg <= regRead ? readMux : RESET_BYTE;
        end
    end

    assign regReadData = readData_reg;
    assign overflowIrq = overflowIrq_reg;
    assign captureIrq = captureIrq_reg;
    assign atCeiling = atCeiling_reg;
    assign atFloor = atFloor_reg;

endmodule

// *** verification/t16cc_timer_assertions.sv ***
// Purpose: Port checks of the 16-bit timer with capture.
// Assumes: Only the top module ports are visible.
// Notes: The temp mirror is trusted only after a high-byte write.
`timescale 1ns/100ps
module t16cc_timer_assertions
    import t16cc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regReadData,
    // Pins and indications
    input wire logic captureInputPin,
    input wire logic comparatorOutput,
    input wire logic overflowIrq,
    input wire logic captureIrq,
    input wire logic captureAck,
    input wire logic atCeiling,
    input wire logic atFloor
);
    logic [7:0] ctrlA_reg, ctrlB_reg, temp_reg, cmpHi_reg;
    logic tempOk_reg, cmpOk_reg, pin_reg, cmp_reg;
    logic [2:0] quiet_reg, up_reg;
    wire hiWr = regWrite && regAddr[0] && regAddr >= ADDR_COUNT_HI &&
        regAddr <= ADDR_CMPB_HI;
    wire loRd = regRead && (regAddr == ADDR_COUNT_LO ||
        regAddr == ADDR_CAPTURE_LO);
    wire [3:0] mode = {ctrlB_reg[4:3], ctrlA_reg[1:0]};
    wire pinsCalm = captureInputPin == pin_reg && comparatorOutput == cmp_reg;
    wire calm = pinsCalm && !regWrite;
    wire loWr = regWrite && regAddr == ADDR_COUNT_LO && tempOk_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {ctrlA_reg, ctrlB_reg, temp_reg, cmpHi_reg} <= '0;
            {tempOk_reg, cmpOk_reg, pin_reg, cmp_reg} <= '0;
            {quiet_reg, up_reg} <= '0;
        end else begin
            if (regWrite && regAddr == ADDR_CTRL_A) ctrlA_reg <= regWriteData;
            if (regWrite && regAddr == ADDR_CTRL_B) ctrlB_reg <= regWriteData;
            if (hiWr) temp_reg <= regWriteData;
            if (hiWr || loRd) tempOk_reg <= hiWr;
            if (regWrite && regAddr == ADDR_CMPA_LO) begin
                cmpHi_reg <= temp_reg;
                cmpOk_reg <= tempOk_reg;
            end
            pin_reg <= captureInputPin;
            cmp_reg <= comparatorOutput;
            quiet_reg <= {quiet_reg[1:0], calm};
            if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
        end
    end
    // Read data stands only in the cycle after a read strobe.
    chk_read_idle: assert property (@(posedge clk) disable iff (!resetn)
        !$past(regRead) |-> regReadData == 8'h00) else $error("stray data");
    chk_unmapped_zero: assert property (@(posedge clk) disable iff (!resetn)
        regRead && regAddr > ADDR_STATUS |=> regReadData == 8'h00)
        else $error("unmapped read not zero");
    chk_temp_hi_read: assert property (@(posedge clk) disable iff (!resetn)
        regRead && tempOk_reg && (regAddr == ADDR_COUNT_HI ||
        regAddr == ADDR_CAPTURE_HI) |=> regReadData == $past(temp_reg))
        else $error("high byte not from temp");
    chk_cmp_direct: assert property (@(posedge clk) disable iff (!resetn)
        regRead && regAddr == ADDR_CMPA_HI && cmpOk_reg |=>
        regReadData == cmpHi_reg) else $error("compare high wrong");
    chk_write_floor: assert property (@(posedge clk) disable iff (!resetn)
        loWr |=> atFloor == ({temp_reg, $past(regWriteData)} == COUNT_FLOOR))
        else $error("floor wrong after write");
    chk_write_ceil: assert property (@(posedge clk) disable iff (!resetn)
        loWr && mode == 4'h0 |=>
        atCeiling == ({temp_reg, $past(regWriteData)} == COUNT_MAX))
        else $error("ceiling wrong after write");
    chk_stop_hold: assert property (@(posedge clk) disable iff (!resetn)
        up_reg == 3'h7 && ctrlB_reg[2:0] == TICK_STOP && !regWrite |=>
        $stable(atFloor)) else $error("stopped count moved");
    chk_ack_clears: assert property (@(posedge clk) disable iff (!resetn)
        captureAck && calm && quiet_reg == 3'h7 |=> !captureIrq)
        else $error("ack left capture request");
    chk_w1c_capture: assert property (@(posedge clk) disable iff (!resetn)
        regWrite && regAddr == ADDR_FLAGS && regWriteData[FLAG_CAP_BIT] &&
        pinsCalm && quiet_reg == 3'h7 |=> !captureIrq)
        else $error("write one left capture request");
    chk_reset_quiet: assert property (@(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> (!overflowIrq && !captureIrq && !atCeiling)[*2])
        else $error("outputs active after reset");
endmodule
bind t16cc_timer t16cc_timer_assertions chk (.clk(clk), .resetn(resetn),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
    .regRead(regRead), .regReadData(regReadData),
    .captureInputPin(captureInputPin), .comparatorOutput(comparatorOutput),
    .overflowIrq(overflowIrq), .captureIrq(captureIrq),
    .captureAck(captureAck), .atCeiling(atCeiling), .atFloor(atFloor));

// *** verification/t16cc_cpu_model.sv ***
// Purpose: Interrupt side of the CPU core on the register port.
// Assumes: Service takes a few cycles after the request rises.
// Notes: Service is held off while a two-byte access runs.
`timescale 1ns/100ps
module t16cc_cpu_model
    import t16cc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Bench control
    input wire logic serviceOn,
    input wire logic atomic,
    // Interrupt handshake
    input wire logic overflowIrq,
    input wire logic captureIrq,
    output logic overflowAck,
    output logic captureAck
);
    logic [1:0] wait_reg;
    wire go = serviceOn && !atomic && wait_reg == 2'h3;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {wait_reg, overflowAck, captureAck} <= '0;
        end else begin
            overflowAck <= go && overflowIrq;
            captureAck <= go && !overflowIrq && captureIrq;
            if (go) wait_reg <= 2'h0;
            else if ((overflowIrq || captureIrq) && wait_reg != 2'h3)
                wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule

// *** verification/test_t16cc_timer.sv ***
// Purpose: Self-checking bench for the 16-bit timer with capture.
// Assumes: One-cycle strobes, read data in the following cycle.
// Notes: Ticks come from the bench only, so every count is exact.
`timescale 1ns/100ps
module test_t16cc_timer
    import t16cc_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] regAddr = 4'h0, prescaleTick = 4'h0;
    logic [7:0] regWriteData = 8'h00, regReadData, b;
    logic regWrite = 1'b0, regRead = 1'b0, externalTickPin = 1'b0;
    logic captureInputPin = 1'b0, comparatorOutput = 1'b0;
    logic serviceOn = 1'b0, atomic = 1'b0;
    logic overflowIrq, captureIrq, overflowAck, captureAck, atCeiling, atFloor;
    logic [15:0] v;
    int failures = 0;
    int check_count = 0;
    always #10 clk = ~clk;
    t16cc_timer dut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .prescaleTick(prescaleTick),
        .externalTickPin(externalTickPin), .captureInputPin(captureInputPin),
        .comparatorOutput(comparatorOutput), .overflowIrq(overflowIrq),
        .captureIrq(captureIrq), .overflowAck(overflowAck),
        .captureAck(captureAck), .atCeiling(atCeiling), .atFloor(atFloor));
    t16cc_cpu_model cpu (.clk(clk), .resetn(resetn), .serviceOn(serviceOn),
        .atomic(atomic), .overflowIrq(overflowIrq), .captureIrq(captureIrq),
        .overflowAck(overflowAck), .captureAck(captureAck));
    task automatic check(string what, logic [15:0] seen, logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regReadData;
    endtask
    // Interrupt service is held off so it cannot disturb the shared temp.
    task automatic w16(logic [3:0] a, logic [15:0] d);
        atomic <= 1'b1;
        wr(a + 4'h1, d[15:8]);
        wr(a, d[7:0]);
        atomic <= 1'b0;
    endtask
    task automatic r16(logic [3:0] a, output logic [15:0] d);
        atomic <= 1'b1;
        rd(a, d[7:0]);
        rd(a + 4'h1, d[15:8]);
        atomic <= 1'b0;
    endtask
    task automatic ticks(logic [7:0] cb, int n);
        wr(ADDR_CTRL_B, cb);
        repeat (n) begin
            @(posedge clk);
            prescaleTick <= (cb[2:0] > 3'h1) ? 4'h1 << (cb[2:0] - 3'h2) : 4'h0;
            externalTickPin <= 1'b1;
            @(posedge clk);
            prescaleTick <= ~prescaleTick;
            externalTickPin <= 1'b0;
        end
        repeat (2) @(posedge clk);
        prescaleTick <= 4'h0;
        wr(ADDR_CTRL_B, cb & 8'hf8);
    endtask
    task automatic capt(logic [7:0] cb, logic [15:0] c, logic p, logic q,
        logic [15:0] cap, logic [7:0] flag);
        w16(ADDR_COUNT_LO, c);
        wr(ADDR_CTRL_B, cb);
        repeat (4) @(posedge clk);
        wr(ADDR_FLAGS, 8'h20);
        captureInputPin <= p;
        comparatorOutput <= q;
        repeat (12) @(posedge clk);
        rd(ADDR_FLAGS, b);
        check("capture flag", b, flag);
        r16(ADDR_CAPTURE_LO, v);
        check("capture value", v, cap);
    endtask
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end
    initial begin
        do_reset();
        for (int a = 0; a < 16; a++) begin
            rd(4'(a), b);
            check("reset read", b, (4'(a) == ADDR_STATUS) ? 8'h02 : 8'h00);
        end
        $display("test reset values done");
        w16(ADDR_COUNT_LO, 16'h01ff);
        repeat (20) @(posedge clk);
        r16(ADDR_COUNT_LO, v);
        check("stopped count", v, 16'h01ff);
        w16(ADDR_COUNT_LO, 16'h1234);
        wr(ADDR_CMPB_LO, 8'h56);
        w16(ADDR_CMPA_LO, 16'h9abc);
        rd(ADDR_COUNT_HI, b);
        check("stale temp", b, 8'h9a);
        rd(ADDR_COUNT_LO, b);
        rd(ADDR_CMPA_HI, b);
        check("compare a high", b, 8'h9a);
        rd(ADDR_COUNT_HI, b);
        check("count high", b, 8'h12);
        r16(ADDR_CMPB_LO, v);
        check("compare b", v, 16'h1256);
        $display("test shared temp done");
        for (int s = 2; s < 8; s++) begin
            w16(ADDR_COUNT_LO, 16'h00fe);
            ticks(8'(s), 3);
            r16(ADDR_COUNT_LO, v);
            check("up count", v, 16'h0101);
        end
        wr(ADDR_CTRL_A, 8'h01);
        w16(ADDR_COUNT_LO, 16'h00fe);
        ticks(8'h02, 3);
        r16(ADDR_COUNT_LO, v);
        check("dual slope", v, 16'h00fd);
        wr(ADDR_CTRL_A, 8'h00);
        w16(ADDR_CMPA_LO, 16'h0005);
        w16(ADDR_COUNT_LO, 16'h0004);
        ticks(8'h0a, 3);
        r16(ADDR_COUNT_LO, v);
        check("clear at top", v, 16'h0001);
        wr(ADDR_CTRL_B, 8'h00);
        w16(ADDR_COUNT_LO, 16'hffff);
        #1;
        check("ceiling", atCeiling, 1'b1);
        ticks(8'h02, 1);
        rd(ADDR_FLAGS, b);
        check("overflow flag", b, 8'h01);
        check("floor", atFloor, 1'b1);
        serviceOn <= 1'b1;
        wr(ADDR_IRQ_MASK, 8'h01);
        repeat (12) @(posedge clk);
        rd(ADDR_FLAGS, b);
        check("overflow serviced", b, 8'h00);
        $display("test counting done");
        capt(8'h00, 16'h0500, 1'b1, 1'b0, 16'h0000, 8'h00);
        capt(8'h00, 16'h0400, 1'b0, 1'b0, 16'h0400, 8'h20);
        capt(8'h40, 16'h0100, 1'b1, 1'b0, 16'h0100, 8'h20);
        capt(8'h60, 16'h0200, 1'b1, 1'b1, 16'h0200, 8'h20);
        capt(8'h20, 16'h0300, 1'b1, 1'b0, 16'h0300, 8'h20);
        wr(ADDR_FLAGS, 8'h00);
        rd(ADDR_FLAGS, b);
        check("flag after zero", b, 8'h20);
        wr(ADDR_FLAGS, 8'h20);
        rd(ADDR_FLAGS, b);
        check("flag after one", b, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h21);
        capt(8'h00, 16'h0600, 1'b0, 1'b0, 16'h0600, 8'h00);
        $display("test capture done");
        w16(ADDR_CAPTURE_LO, 16'h4321);
        r16(ADDR_CAPTURE_LO, v);
        check("capture locked", v, 16'h0600);
        wr(ADDR_CTRL_B, 8'h18);
        w16(ADDR_CAPTURE_LO, 16'h4321);
        r16(ADDR_CAPTURE_LO, v);
        check("capture as top", v, 16'h4321);
        $display("test capture write done");
        do_reset();
        r16(ADDR_COUNT_LO, v);
        check("count after reset", v, 16'h0000);
        rd(ADDR_CTRL_B, b);
        check("control after reset", b, 8'h00);
        $display("test second reset done");
        close_out();
    end
endmodule
